// *** lagc_loudness.sv ***
// What this block does
// - Master off ramps correction smoothly to unity
// - Master on derives correction from measured loudness
// - Current applied correction readable as status
// - Silence threshold 0 to -70, default -40
// - Target level 0 to -50, default -24
// - Spread 0 to 50 sets window, default 1
// - Transition time 0.5 to 30 s, default 3
// - Attenuation never beyond limit, 0 to -12
// - Boost never beyond limit, 0 to +12
// - Each of sixteen channels measured and corrected
// - Two-minute four-trace history for selected channel
// - Output trace is average plus correction, plus mixer gain when the post bit is set
// - Correction runs regardless of trace reading
// - Link channels singly, in pairs, or grouped
//
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/10ps
module lagc_loudness #(
  parameter int NCH = 16,
  parameter int TRACE_DEPTH = lagc_pkg::TRACE_DEPTH,
  parameter int RAMP_PRESCALE = lagc_pkg::RAMP_PRESCALE,
  parameter int TRACE_CYCLES = lagc_pkg::TRACE_CYCLES,
  localparam int CHW = $clog2(NCH)
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic inValid,
  output logic inReady,
  input wire logic [CHW-1:0] inChannel,
  input wire logic signed [7:0] inLevel,
  input wire logic signed [7:0] mixerGain,
  output logic outValid,
  input wire logic outReady,
  output logic [CHW-1:0] outChannel,
  output logic signed [15:0] outCorrection
);

  localparam int TIW = $clog2(TRACE_DEPTH);
  localparam int TCW = $clog2(TRACE_DEPTH + 1);

  logic [lagc_pkg::CTRL_W-1:0] ctrlReg;
  logic signed [7:0] silenceReg;
  logic signed [7:0] targetReg;
  logic signed [7:0] spreadReg;
  logic signed [7:0] transReg;
  logic signed [7:0] attenReg;
  logic signed [7:0] gainReg;
  logic [TIW-1:0] traceIdxReg;
  logic signed [15:0] statusReg;
  logic signed [7:0] lastInReg;
  logic [31:0] readMux;
  logic wbReq;

  logic en;
  logic post;
  lagc_pkg::lagc_link_t linkMode;
  logic [CHW-1:0] chartCh;
  logic [NCH-1:0] groupMask;

  logic signed [15:0] avgMem [NCH];
  logic signed [15:0] corrMem [NCH];
  logic [15:0] stepMem [NCH];
  logic [NCH-1:0] movingMem;

  function automatic logic signed [7:0] clampS8(input logic signed [7:0] v,
    input logic signed [7:0] lo, input logic signed [7:0] hi);
    clampS8 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic signed [16:0] sx(input logic signed [15:0] v);
    sx = {v[15], v};
  endfunction

  function automatic logic signed [15:0] toQ(input logic signed [7:0] v);
    toQ = {v, 8'h00};
  endfunction

  function automatic logic [CHW-1:0] leaderOf(input logic [CHW-1:0] c);
    logic [CHW-1:0] first;
    first = c;
    for (int i = NCH - 1; i >= 0; i--)
      if (groupMask[i])
        first = CHW'(i);
    case (linkMode)
      lagc_pkg::LINK_PAIR: leaderOf = {c[CHW-1:1], 1'b0};
      lagc_pkg::LINK_GROUP: leaderOf = groupMask[c] ? first : c;
      default: leaderOf = c;
    endcase
  endfunction

  assign en = ctrlReg[lagc_pkg::CTRL_EN_BIT];
  assign post = ctrlReg[lagc_pkg::CTRL_POST_BIT];
  assign linkMode = lagc_pkg::lagc_link_t'(
    ctrlReg[lagc_pkg::CTRL_LINK_LSB +: lagc_pkg::CTRL_LINK_W]);
  assign chartCh = ctrlReg[lagc_pkg::CTRL_CHART_LSB +: CHW];
  assign groupMask = ctrlReg[lagc_pkg::CTRL_MASK_LSB +: NCH];

  // Bus slave, one wait state, ack for one cycle
  assign wbReq = cyc_i && stb_i && !ack_o;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end
    else
    begin
      ack_o <= wbReq;
      dat_o <= (wbReq && !we_i) ? readMux : 32'h00000000;
    end
  end

  // Settings clamp to their settable range on write
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrlReg <= lagc_pkg::CTRL_RST;
      silenceReg <= lagc_pkg::SILENCE_RST;
      targetReg <= lagc_pkg::TARGET_RST;
      spreadReg <= lagc_pkg::SPREAD_RST;
      transReg <= lagc_pkg::TRANS_RST;
      attenReg <= lagc_pkg::MAXATTEN_RST;
      gainReg <= lagc_pkg::MAXGAIN_RST;
      traceIdxReg <= '0;
    end
    else if (wbReq && we_i)
    begin
      case (adr_i)
        lagc_pkg::ADDR_CTRL:
        begin
          for (int b = 0; b < lagc_pkg::CTRL_W / 8; b++)
            if (sel_i[b])
              ctrlReg[8*b +: 8] <= dat_i[8*b +: 8];
        end
        lagc_pkg::ADDR_SILENCE:
          if (sel_i[0])
            silenceReg <= clampS8(dat_i[7:0], lagc_pkg::SILENCE_MIN,
              lagc_pkg::LVL_ZERO);
        lagc_pkg::ADDR_TARGET:
          if (sel_i[0])
            targetReg <= clampS8(dat_i[7:0], lagc_pkg::TARGET_MIN,
              lagc_pkg::LVL_ZERO);
        lagc_pkg::ADDR_SPREAD:
          if (sel_i[0])
            spreadReg <= clampS8(dat_i[7:0], lagc_pkg::LVL_ZERO,
              lagc_pkg::SPREAD_MAX);
        lagc_pkg::ADDR_TRANS:
          if (sel_i[0])
            transReg <= clampS8(dat_i[7:0], lagc_pkg::TRANS_MIN,
              lagc_pkg::TRANS_MAX);
        lagc_pkg::ADDR_MAXATTEN:
          if (sel_i[0])
            attenReg <= clampS8(dat_i[7:0], lagc_pkg::ATTEN_MIN,
              lagc_pkg::LVL_ZERO);
        lagc_pkg::ADDR_MAXGAIN:
          if (sel_i[0])
            gainReg <= clampS8(dat_i[7:0], lagc_pkg::LVL_ZERO,
              lagc_pkg::GAIN_MAX);
        lagc_pkg::ADDR_TRACE_IDX:
          if (sel_i[0])
            traceIdxReg <= dat_i[TIW-1:0];
        default:
          ;
      endcase
    end
  end

  // Input stream: averaging per channel
  logic acc;
  logic signed [16:0] avgDiff;
  logic signed [15:0] avgNext;

  assign acc = inValid && inReady;
  assign avgDiff = sx(toQ(inLevel)) - sx(avgMem[inChannel]);
  assign avgNext = avgMem[inChannel]
    + 16'(avgDiff >>> lagc_pkg::AVG_SHIFT);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < NCH; i++)
        avgMem[i] <= 16'sh0000;
    end
    else if (acc)
      avgMem[inChannel] <= avgNext;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      lastInReg <= 8'sh00;
    else if (acc && inChannel == chartCh)
      lastInReg <= inLevel;
  end

  // Ramp tick: full change spans 2^RAMP_SHIFT ticks of one transition time
  logic [31:0] preCnt;
  logic [7:0] unitCnt;
  logic rampTick;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      preCnt <= 32'h00000000;
      unitCnt <= 8'h00;
      rampTick <= 1'b0;
    end
    else
    begin
      rampTick <= 1'b0;
      if (preCnt == 32'(RAMP_PRESCALE - 1))
      begin
        preCnt <= 32'h00000000;
        if (unitCnt >= transReg - 8'sh01)
        begin
          unitCnt <= 8'h00;
          rampTick <= 1'b1;
        end
        else
          unitCnt <= unitCnt + 8'h01;
      end
      else
        preCnt <= preCnt + 32'h00000001;
    end
  end

  // Sweep visits every channel once per tick that arrives while no sweep is active
  logic sweepActive;
  logic [CHW-1:0] sweepCh;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sweepActive <= 1'b0;
      sweepCh <= '0;
    end
    else if (rampTick && !sweepActive)
    begin
      sweepActive <= 1'b1;
      sweepCh <= '0;
    end
    else if (sweepActive)
    begin
      if (sweepCh == CHW'(NCH - 1))
        sweepActive <= 1'b0;
      sweepCh <= sweepCh + 1'b1;
    end
  end

  // Desired correction and linear step for the swept channel
  logic signed [15:0] avgS;
  logic signed [15:0] corrS;
  logic signed [15:0] attenQ;
  logic signed [15:0] gainQ;
  logic signed [15:0] silQ;
  logic signed [16:0] outLvl;
  logic signed [16:0] desRaw;
  logic signed [15:0] des;
  logic signed [16:0] diff;
  logic [16:0] mag;
  logic [15:0] newStep;
  logic [15:0] stepUse;
  logic signed [15:0] corrNext;
  logic movingNext;

  assign attenQ = toQ(attenReg);
  assign gainQ = toQ(gainReg);
  assign silQ = toQ(silenceReg);

  always_comb
  begin
    avgS = avgMem[sweepCh];
    corrS = corrMem[sweepCh];
    outLvl = sx(avgS) + sx(corrS);
    if (!en)
      desRaw = 17'sh00000;
    else if (avgS <= silQ)
      desRaw = sx(corrS);
    else if (outLvl >= sx(toQ(targetReg)) - sx(toQ(spreadReg)) &&
             outLvl <= sx(toQ(targetReg)) + sx(toQ(spreadReg)))
      desRaw = sx(corrS);
    else
      desRaw = sx(toQ(targetReg)) - sx(avgS);
    if (desRaw < sx(attenQ))
      des = attenQ;
    else if (desRaw > sx(gainQ))
      des = gainQ;
    else
      des = desRaw[15:0];
    diff = sx(des) - sx(corrS);
    mag = (diff < 0) ? 17'(-diff) : 17'(diff);
    newStep = 16'(mag >> lagc_pkg::RAMP_SHIFT);
    if (newStep == 16'h0000)
      newStep = 16'h0001;
    stepUse = movingMem[sweepCh] ? stepMem[sweepCh] : newStep;
    if (diff == 0)
    begin
      corrNext = corrS;
      movingNext = 1'b0;
    end
    else if (mag <= {1'b0, stepUse})
    begin
      corrNext = des;
      movingNext = 1'b0;
    end
    else
    begin
      corrNext = (diff > 0) ? corrS + stepUse : corrS - stepUse;
      movingNext = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        corrMem[i] <= 16'sh0000;
        stepMem[i] <= 16'h0000;
      end
      movingMem <= '0;
    end
    else if (sweepActive)
    begin
      corrMem[sweepCh] <= corrNext;
      stepMem[sweepCh] <= stepUse;
      movingMem[sweepCh] <= movingNext;
    end
  end

  // Correction stream to the mixer, through the two-word buffer
  logic [CHW+15:0] bufIn;
  logic [CHW+15:0] bufOut;

  // Leader lookup reads the link settings, so it must sit in always_comb
  always_comb
  begin
    bufIn = {inChannel, corrMem[leaderOf(inChannel)]};
  end
  assign outChannel = bufOut[CHW+15:16];
  assign outCorrection = bufOut[15:0];

  lagc_pair_buf #(
    .W(CHW + 16)
  ) u_buf (
    .clk(clk),
    .arst_n(arst_n),
    .sValid(inValid),
    .sReady(inReady),
    .sData(bufIn),
    .mValid(outValid),
    .mReady(outReady),
    .mData(bufOut)
  );

  // Chart channel status and history
  logic signed [15:0] avgChart;
  logic signed [15:0] corrChart;
  logic signed [15:0] finalQ;
  logic [31:0] secCnt;
  logic [TIW-1:0] wp;
  logic [TCW-1:0] fill;
  logic [31:0] traceMem [TRACE_DEPTH];
  logic [31:0] traceWord;
  logic [TIW-1:0] rdPos;

  assign avgChart = avgMem[chartCh];
  always_comb
  begin
    corrChart = corrMem[leaderOf(chartCh)];
  end
  assign finalQ = avgChart + corrChart
    + (post ? toQ(mixerGain) : 16'sh0000);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      statusReg <= 16'sh0000;
    else
      statusReg <= corrChart;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      secCnt <= 32'h00000000;
      wp <= '0;
      fill <= '0;
    end
    else if (secCnt == 32'(TRACE_CYCLES - 1))
    begin
      secCnt <= 32'h00000000;
      wp <= (wp == TIW'(TRACE_DEPTH - 1)) ? '0 : wp + 1'b1;
      if (fill != TCW'(TRACE_DEPTH))
        fill <= fill + 1'b1;
    end
    else
      secCnt <= secCnt + 32'h00000001;
  end

  always_ff @(posedge clk)
  begin
    if (secCnt == 32'(TRACE_CYCLES - 1))
      traceMem[wp] <= {lastInReg, avgChart[15:8], corrChart[15:8],
        finalQ[15:8]};
  end

  always_comb
  begin
    rdPos = (wp > traceIdxReg) ? wp - 1'b1 - traceIdxReg
      : TIW'(TRACE_DEPTH - 1) - traceIdxReg + wp;
    traceWord = (TCW'(traceIdxReg) < fill) ? traceMem[rdPos] : 32'h00000000;
  end

  always_comb
  begin
    case (adr_i)
      lagc_pkg::ADDR_CTRL: readMux = {8'h00, ctrlReg};
      lagc_pkg::ADDR_SILENCE: readMux = {24'h000000, silenceReg};
      lagc_pkg::ADDR_TARGET: readMux = {24'h000000, targetReg};
      lagc_pkg::ADDR_SPREAD: readMux = {24'h000000, spreadReg};
      lagc_pkg::ADDR_TRANS: readMux = {24'h000000, transReg};
      lagc_pkg::ADDR_MAXATTEN: readMux = {24'h000000, attenReg};
      lagc_pkg::ADDR_MAXGAIN: readMux = {24'h000000, gainReg};
      lagc_pkg::ADDR_STATUS: readMux = {16'h0000, statusReg};
      lagc_pkg::ADDR_TRACE_IDX: readMux = 32'(traceIdxReg);
      lagc_pkg::ADDR_TRACE_DATA: readMux = traceWord;
      default: readMux = 32'h00000000;
    endcase
  end

  a_ack_pulse: assert property (@(posedge clk) disable iff (!arst_n)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  a_ack_answer: assert property (@(posedge clk) disable iff (!arst_n)
    cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered next cycle");

  a_off_unity: assert property (@(posedge clk) disable iff (!arst_n)
    sweepActive && !en |-> des == 16'sh0000 ##1 corrMem[$past(sweepCh)]
      == $past(corrNext))
    else $error("correction not steered to unity when off");

  a_atten_floor: assert property (@(posedge clk) disable iff (!arst_n)
    sweepActive |-> des >= attenQ)
    else $error("target correction below attenuation limit");

  a_gain_ceiling: assert property (@(posedge clk) disable iff (!arst_n)
    sweepActive |-> des <= gainQ)
    else $error("target correction above gain limit");

  a_ramp_linear: assert property (@(posedge clk) disable iff (!arst_n)
    sweepActive |-> sx(corrNext) - sx(corrS) <= $signed({1'b0, stepUse})
      && sx(corrS) - sx(corrNext) <= $signed({1'b0, stepUse}))
    else $error("correction moved more than one step");

  a_silence_hold: assert property (@(posedge clk) disable iff (!arst_n)
    sweepActive && en && avgS <= silQ && corrS >= attenQ && corrS <= gainQ
      |-> des == corrS && corrNext == corrS)
    else $error("silent channel correction changed");

  a_silence_range: assert property (@(posedge clk) disable iff (!arst_n)
    silenceReg >= lagc_pkg::SILENCE_MIN && silenceReg <= lagc_pkg::LVL_ZERO)
    else $error("silence threshold out of range");

  a_sweep_start: assert property (@(posedge clk) disable iff (!arst_n)
    rampTick && !sweepActive |=> sweepActive && sweepCh == '0)
    else $error("ramp tick did not start a sweep");

endmodule

// *** lagc_mixer_model.sv ***
`timescale 1ns/10ps
module lagc_mixer_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sendEn,
  input wire logic [3:0] sendChannel,
  input wire logic signed [7:0] sendLevel,
  input wire logic stall,
  input wire logic inReady,
  output logic inValid,
  output logic [3:0] inChannel,
  output logic signed [7:0] inLevel,
  input wire logic outValid,
  output logic outReady,
  input wire logic [3:0] outChannel,
  input wire logic signed [15:0] outCorrection,
  output logic [3:0] lastChannel,
  output logic signed [15:0] lastCorr
);
  assign outReady = !stall;

  // Source holds a word until taken; idle lines toggle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      inValid <= 1'b0;
      inChannel <= 4'h0;
      inLevel <= 8'h00;
    end
    else if (!inValid || inReady)
    begin
      inValid <= sendEn;
      inChannel <= sendEn ? sendChannel : ~inChannel;
      inLevel <= sendEn ? sendLevel : ~inLevel;
    end
  end

  // Sink keeps the last word it took
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lastChannel <= 4'h0;
      lastCorr <= 16'h0000;
    end
    else if (outValid && outReady)
    begin
      lastChannel <= outChannel;
      lastCorr <= outCorrection;
    end
  end
endmodule

// *** lagc_pair_buf.sv ***
`timescale 1ns/10ps
module lagc_pair_buf #(
  parameter int W = 20
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sValid,
  output logic sReady,
  input wire logic [W-1:0] sData,
  output logic mValid,
  input wire logic mReady,
  output logic [W-1:0] mData
);

  logic [W-1:0] tailReg;
  logic [1:0] countReg;
  logic [1:0] countNext;
  logic push;
  logic pop;

  assign push = sValid && sReady;
  assign pop = mValid && mReady;

  always_comb
  begin
    countNext = countReg;
    if (push && !pop)
      countNext = countReg + 2'h1;
    else if (!push && pop)
      countNext = countReg - 2'h1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mData <= '0;
      tailReg <= '0;
    end
    else if (push && !pop)
    begin
      if (countReg == 2'h0)
        mData <= sData;
      else
        tailReg <= sData;
    end
    else if (!push && pop)
      mData <= tailReg;
    else if (push && pop)
    begin
      if (countReg == 2'h1)
        mData <= sData;
      else
      begin
        mData <= tailReg;
        tailReg <= sData;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      countReg <= 2'h0;
      mValid <= 1'b0;
      sReady <= 1'b0;
    end
    else
    begin
      countReg <= countNext;
      mValid <= countNext != 2'h0;
      sReady <= countNext != 2'h2;
    end
  end

  a_buf_stall: assert property (@(posedge clk) disable iff (!arst_n)
    countReg == 2'h2 && !mReady |=> !sReady && mValid)
    else $error("buffer took a word while full");

endmodule

// *** lagc_pkg.sv ***
package lagc_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SILENCE = 8'h04;
  localparam logic [7:0] ADDR_TARGET = 8'h08;
  localparam logic [7:0] ADDR_SPREAD = 8'h0c;
  localparam logic [7:0] ADDR_TRANS = 8'h10;
  localparam logic [7:0] ADDR_MAXATTEN = 8'h14;
  localparam logic [7:0] ADDR_MAXGAIN = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_TRACE_IDX = 8'h20;
  localparam logic [7:0] ADDR_TRACE_DATA = 8'h24;

  // Control register layout
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_POST_BIT = 1;
  localparam int CTRL_LINK_LSB = 2;
  localparam int CTRL_LINK_W = 2;
  localparam int CTRL_CHART_LSB = 4;
  localparam int CTRL_MASK_LSB = 8;
  localparam int CTRL_W = 24;
  localparam logic [23:0] CTRL_RST = 24'h003f00;

  // Reset values, whole dB (LKFS) or half-second units
  localparam logic signed [7:0] SILENCE_RST = 8'hd8;
  localparam logic signed [7:0] TARGET_RST = 8'he8;
  localparam logic signed [7:0] SPREAD_RST = 8'h01;
  localparam logic signed [7:0] TRANS_RST = 8'h06;
  localparam logic signed [7:0] MAXATTEN_RST = 8'hf4;
  localparam logic signed [7:0] MAXGAIN_RST = 8'h0c;

  // Settable ranges
  localparam logic signed [7:0] LVL_ZERO = 8'h00;
  localparam logic signed [7:0] SILENCE_MIN = 8'hba;
  localparam logic signed [7:0] TARGET_MIN = 8'hce;
  localparam logic signed [7:0] SPREAD_MAX = 8'h32;
  localparam logic signed [7:0] TRANS_MIN = 8'h01;
  localparam logic signed [7:0] TRANS_MAX = 8'h3c;
  localparam logic signed [7:0] ATTEN_MIN = 8'hf4;
  localparam logic signed [7:0] GAIN_MAX = 8'h0c;

  typedef enum logic [1:0] {LINK_SINGLE, LINK_PAIR, LINK_GROUP} lagc_link_t;

  // Arithmetic: levels and corrections are Q8.8 dB
  localparam int FRAC_BITS = 8;
  localparam int AVG_SHIFT = 4;
  localparam int RAMP_SHIFT = 8;

  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int TRANS_UNIT_MS = 500;
  localparam int TRACE_PERIOD_MS = 1000;
  localparam int TRACE_SPAN_S = 120;
  localparam int UNIT_CYCLES = TRANS_UNIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int RAMP_PRESCALE = UNIT_CYCLES >> RAMP_SHIFT;
  localparam int TRACE_CYCLES = TRACE_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TRACE_DEPTH = TRACE_SPAN_S * 1000 / TRACE_PERIOD_MS;

endpackage

// *** tb.sv ***
`timescale 1ns/10ps
module tb;
  logic clk, arstN, cyc, stb, we, ack, inValid, inReady, outValid, outReady;
  logic sendEn, stall;
  logic [7:0] adr;
  logic [3:0] sel, inCh, outCh, lastCh, sendCh;
  logic [31:0] wdat, rdat, q;
  logic signed [7:0] inLvl, sendLvl, mixGain;
  logic signed [15:0] outCorr, lastCorr;
  int mismatches, samplesChecked, cycles;
  logic [31:0] rstTab [0:9] = '{32'h00003f00, 32'h040000d8, 32'h080000e8,
    32'h0c000001, 32'h10000006, 32'h140000f4, 32'h1800000c, 32'h1c000000,
    32'h20000000, 32'h30000000};
  logic [23:0] clampTab [0:8] = '{24'h04b0ba, 24'h040500, 24'h08c0ce,
    24'h0c4032, 24'h0cff00, 24'h100001, 24'h10503c, 24'h14f0f4, 24'h18200c};
  logic [1:0] linkOrd [0:3] = '{2'h0, 2'h3, 2'h1, 2'h2};

  lagc_loudness #(.NCH(16), .TRACE_DEPTH(8), .RAMP_PRESCALE(2),
    .TRACE_CYCLES(20)) u_dut (.clk(clk), .arst_n(arstN), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
    .dat_o(rdat), .ack_o(ack), .inValid(inValid), .inReady(inReady),
    .inChannel(inCh), .inLevel(inLvl), .mixerGain(mixGain),
    .outValid(outValid), .outReady(outReady), .outChannel(outCh),
    .outCorrection(outCorr));

  lagc_mixer_model u_mixer (.clk(clk), .arst_n(arstN), .sendEn(sendEn),
    .sendChannel(sendCh), .sendLevel(sendLvl), .stall(stall),
    .inReady(inReady), .inValid(inValid), .inChannel(inCh), .inLevel(inLvl),
    .outValid(outValid), .outReady(outReady), .outChannel(outCh),
    .outCorrection(outCorr), .lastChannel(lastCh), .lastCorr(lastCorr));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic complete_run();
    $display("Mismatches %0d, checks %0d", mismatches, samplesChecked);
    if (mismatches == 0 && samplesChecked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 90000)
    begin
      mismatches = mismatches + 1;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic between(input logic signed [15:0] got,
    input logic signed [15:0] lo, input logic signed [15:0] hi);
    check({31'h0, got > lo && got < hi}, 32'h1);
  endtask

  // Classic cycle: hold the request until ack is seen at an edge
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do @(posedge clk); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask

  task automatic waitStatus(input logic [15:0] exp);
    int n;
    n = 0;
    do
    begin
      wb(1'b0, lagc_pkg::ADDR_STATUS, 32'h0, q);
      n++;
    end while (q !== {16'h0000, exp} && n < 8000);
    check(q, {16'h0000, exp});
  endtask

  initial
  begin
    arstN = 1'b0;
    {cyc, stb, we, sendEn, stall} = 5'h00;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    sendCh = 4'h0;
    sendLvl = 8'h00;
    mixGain = 8'h02;
    mismatches = 0;
    samplesChecked = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    arstN <= 1'b1;
    wr(8'h30, 32'h000000ff);
    for (int i = 0; i < 10; i++)
      rdc(rstTab[i][31:24],
        {8'h00, rstTab[i][23:0]});
    for (int i = 0; i < 9; i++)
    begin
      wr(clampTab[i][23:16], {24'h0, clampTab[i][15:8]});
      rdc(clampTab[i][23:16],
        {24'h0, clampTab[i][7:0]});
    end
    wr(lagc_pkg::ADDR_TARGET, 32'h000000e8);
    wr(lagc_pkg::ADDR_MAXATTEN, 32'h000000fa);
    wr(lagc_pkg::ADDR_TRANS, 32'h00000001);
    wr(lagc_pkg::ADDR_MAXGAIN, 32'h00000003);
    wr(lagc_pkg::ADDR_CTRL, 32'h00003f31);
    sendCh <= 4'h3;
    sendLvl <= 8'h05;
    sendEn <= 1'b1;
    repeat (100) @(posedge clk);
    wb(1'b0, lagc_pkg::ADDR_STATUS, 32'h0, q);
    between(q[15:0], 16'hfa00, 16'h0000);
    waitStatus(16'hfa00);
    repeat (200) @(posedge clk);
    rdc(lagc_pkg::ADDR_STATUS, 32'h0000fa00);
    // Buffer fills and refuses while the sink stalls, then drains
    stall <= 1'b1;
    repeat (10) @(posedge clk);
    check({30'h0, inReady, outValid}, 32'h1);
    stall <= 1'b0;
    sendEn <= 1'b0;
    repeat (10) @(posedge clk);
    check({31'h0, outValid}, 32'h0);
    sendCh <= 4'h5;
    sendLvl <= 8'h00;
    sendEn <= 1'b1;
    repeat (20) @(posedge clk);
    check({12'h0, lastCh, lastCorr},
      32'h00050000);
    wr(lagc_pkg::ADDR_SILENCE, 32'h000000ba);
    wr(lagc_pkg::ADDR_TARGET, 32'h00000000);
    wr(lagc_pkg::ADDR_CTRL, 32'h00003f51);
    sendLvl <= 8'hec;
    waitStatus(16'h0300);
    for (int m = 0; m < 4; m++)
    begin
      wr(lagc_pkg::ADDR_CTRL, 32'h00003f51 | {28'h0, linkOrd[m], 2'h0});
      repeat (20) @(posedge clk);
      check({12'h0, lastCh, lastCorr},
        {16'h0005, (^linkOrd[m]) ? 16'h0000 : 16'h0300});
    end
    wr(lagc_pkg::ADDR_CTRL, 32'h00003f51);
    wr(lagc_pkg::ADDR_TRACE_IDX, 32'h0);
    repeat (60) @(posedge clk);
    rdc(lagc_pkg::ADDR_TRACE_DATA, 32'hecec03ef);
    wr(lagc_pkg::ADDR_CTRL, 32'h00003f53);
    repeat (60) @(posedge clk);
    rdc(lagc_pkg::ADDR_TRACE_DATA, 32'hecec03f1);
    rdc(lagc_pkg::ADDR_STATUS, 32'h00000300);
    wr(lagc_pkg::ADDR_CTRL, 32'h00003f50);
    repeat (30) @(posedge clk);
    wb(1'b0, lagc_pkg::ADDR_STATUS, 32'h0, q);
    between(q[15:0], 16'h0000, 16'h0300);
    waitStatus(16'h0000);
    complete_run();
  end
endmodule
